/* design/imu_timing_pkg.sv */
// constants and types shared by the sensor and host ends of the inertial link
`default_nettype none
package imu_timing_pkg;
  // ----------------------------------------
  // clock
  // ----------------------------------------
  localparam int CLK_HZ     = 25_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1_000;
  localparam int CNT_W      = 23;
  localparam int WORD_BITS  = 16;
  // ----------------------------------------
  // mode and sample rate
  // ----------------------------------------
  localparam logic [7:0] LOW_POWER_MIN_SETTING = 8'h0a;
  localparam logic [7:0] SETTING_MIN           = 8'h01;
  localparam logic [7:0] SETTING_MAX           = 8'hff;
  localparam int MAX_RATE_DECI_SPS = 8192;
  localparam int SAMPLE_BASE_CYC   = CLK_HZ * 10 / MAX_RATE_DECI_SPS;
  // ----------------------------------------
  // functional times, ms
  // ----------------------------------------
  localparam int STARTUP_NORMAL_MS = 180;
  localparam int STARTUP_LOW_MS    = 250;
  localparam int RESET_NORMAL_MS   = 60;
  localparam int RESET_LOW_MS      = 130;
  localparam int SLEEP_NORMAL_MS   = 4;
  localparam int SLEEP_LOW_MS      = 9;
  localparam int NVM_NORMAL_MS     = 17;
  localparam int NVM_LOW_MS        = 90;
  // ----------------------------------------
  // link times, us
  // ----------------------------------------
  localparam int WAKE_PULSE_US     = 20;
  localparam int WAKE_PULSE_CYC    = WAKE_PULSE_US * CYC_PER_US;
  localparam int STALL_NORMAL_US   = 9;
  localparam int STALL_NORMAL_CYC  = STALL_NORMAL_US * CYC_PER_US;
  localparam int STALL_LOW_US      = 75;
  localparam int STALL_LOW_CYC     = STALL_LOW_US * CYC_PER_US;
  localparam int SYNC_HIGH_MIN_US  = 5;
  localparam int SYNC_HIGH_CYC     = SYNC_HIGH_MIN_US * CYC_PER_US;
  localparam int SYNC_LOW_MIN_US   = 100;
  localparam int SYNC_PERIOD_US    = 1000;
  localparam int SYNC_PERIOD_CYC   = SYNC_PERIOD_US * CYC_PER_US;
  localparam int SYNC_TO_DRDY_US   = 600;
  localparam int SYNC_TO_DRDY_CYC  = SYNC_TO_DRDY_US * CYC_PER_US;
  localparam int DRDY_PULSE_US     = 4;
  localparam int DRDY_PULSE_CYC    = DRDY_PULSE_US * CYC_PER_US;
  localparam int SCLK_NORMAL_KHZ   = 2000;
  localparam int SCLK_LOW_KHZ      = 300;
  localparam int SCLK_NORMAL_HALF  = (CYC_PER_MS + 2 * SCLK_NORMAL_KHZ - 1) / (2 * SCLK_NORMAL_KHZ);
  localparam int SCLK_LOW_HALF     = (CYC_PER_MS + 2 * SCLK_LOW_KHZ - 1) / (2 * SCLK_LOW_KHZ);
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_UP = 3'b000,
    ST_RECOVER  = 3'b001,
    ST_RUN      = 3'b010,
    ST_SLEEP    = 3'b011,
    ST_WAKE     = 3'b100,
    ST_NVM_TEST = 3'b101
  } dev_state_type;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_WAKE  = 2'b01,
    H_SHIFT = 2'b10,
    H_STALL = 2'b11
  } host_state_type;
endpackage : imu_timing_pkg
`default_nettype wire

/* design/imu_link_if.sv */
// serial link and sync wires between host and sensor
`default_nettype none
interface imu_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic data_ready_pin;
  logic sync_clock_input;
  modport device (input sclk, input cs_n, input din, input sync_clock_input,
                  output dout, output data_ready_pin);
  modport host   (output sclk, output cs_n, output din, output sync_clock_input,
                  input dout, input data_ready_pin);
endinterface : imu_link_if
`default_nettype wire

/* design/imu_sensor_end.sv */
// sensor end: mode pacing, sample timing, data ready and serial slave
`default_nettype none
// Summary of operation
// - setting 0x0a and above selects low power
// - sample period is setting (at least 1) times base period
// - first data after 180 / 250 ms
// - reset recovery takes 60 / 130 ms
// - sleep recovery takes 4 / 9 ms
// - chip select low 20 us wakes
// - memory test lasts 17 / 90 ms
// - host stalls 9 / 75 us between words
// - sync high 5 us, low 100 us
// - sync runs 0.8 to 1.2 kHz
// - data ready 600 us after sync edge
// - serial clock limits 2 MHz / 300 kHz
// - each sample latches data, pulses ready
// - mode 3, msb first, 16-bit words
module imu_sensor_end
  import imu_timing_pkg::*;
#(
  parameter int STARTUP_NORMAL_CYC = STARTUP_NORMAL_MS * CYC_PER_MS,
  parameter int STARTUP_LOW_CYC    = STARTUP_LOW_MS * CYC_PER_MS,
  parameter int RESET_NORMAL_CYC   = RESET_NORMAL_MS * CYC_PER_MS,
  parameter int RESET_LOW_CYC      = RESET_LOW_MS * CYC_PER_MS,
  parameter int SLEEP_NORMAL_CYC   = SLEEP_NORMAL_MS * CYC_PER_MS,
  parameter int SLEEP_LOW_CYC      = SLEEP_LOW_MS * CYC_PER_MS,
  parameter int NVM_NORMAL_CYC     = NVM_NORMAL_MS * CYC_PER_MS,
  parameter int NVM_LOW_CYC        = NVM_LOW_MS * CYC_PER_MS,
  parameter int BASE_CYC           = SAMPLE_BASE_CYC,
  parameter int SYNC_DRDY_CYC      = SYNC_TO_DRDY_CYC
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // link
  imu_link_if.device                       link,
  // user side
  input  wire logic [7:0]                  sample_period_setting,
  input  wire logic [WORD_BITS-1:0]        sample_data,
  input  wire logic                        sync_mode,
  input  wire logic                        reset_req,
  input  wire logic                        sleep_req,
  input  wire logic                        nvm_test_req,
  output logic                             low_power,
  output logic                             data_valid,
  output logic                             nvm_busy,
  output logic                             asleep,
  output logic [WORD_BITS-1:0]             rx_word,
  output logic                             rx_valid
);
  import imu_timing_pkg::*;

  typedef struct packed {
    dev_state_type        state;
    logic [CNT_W-1:0]     cnt;
    logic [CNT_W-1:0]     base_cnt;
    logic [7:0]           period_cnt;
    logic [CNT_W-1:0]     sync_cnt;
    logic                 sync_wait;
    logic [9:0]           wake_cnt;
    logic [7:0]           drdy_cnt;
    logic                 sclk_m, sclk_s, sclk_d;
    logic                 cs_m, cs_s, cs_d;
    logic                 din_m, din_s;
    logic                 sync_m, sync_s, sync_d;
    logic [WORD_BITS-1:0] tx_sh;
    logic [WORD_BITS-1:0] rx_sh;
    logic [4:0]           bit_cnt;
    logic [WORD_BITS-1:0] out_word;
    logic                 dout;
    logic                 drdy;
    logic                 low_power;
    logic                 data_valid;
    logic [WORD_BITS-1:0] rx_word;
    logic                 rx_valid;
    logic                 nvm_busy;
    logic                 asleep;
  } dev_regs_type;

  dev_regs_type r;
  dev_regs_type next_r;
  logic             lp;
  logic [CNT_W-1:0] limit;
  logic [7:0]       period;
  logic             sample_now;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r          = r;
    next_r.rx_valid = 1'b0;
    lp              = (sample_period_setting >= LOW_POWER_MIN_SETTING);
    next_r.low_power = lp;
    period = (sample_period_setting < SETTING_MIN) ? SETTING_MIN : sample_period_setting;
    sample_now = 1'b0;
    // pin synchronisers
    next_r.sclk_m = link.sclk;
    next_r.sclk_s = r.sclk_m;
    next_r.sclk_d = r.sclk_s;
    next_r.cs_m   = link.cs_n;
    next_r.cs_s   = r.cs_m;
    next_r.cs_d   = r.cs_s;
    next_r.din_m  = link.din;
    next_r.din_s  = r.din_m;
    next_r.sync_m = link.sync_clock_input;
    next_r.sync_s = r.sync_m;
    next_r.sync_d = r.sync_s;
    // mode-dependent delay of the current state
    case (r.state)
      ST_POWER_UP: limit = lp ? CNT_W'(STARTUP_LOW_CYC - 1) : CNT_W'(STARTUP_NORMAL_CYC - 1);
      ST_RECOVER:  limit = lp ? CNT_W'(RESET_LOW_CYC - 1) : CNT_W'(RESET_NORMAL_CYC - 1);
      ST_WAKE:     limit = lp ? CNT_W'(SLEEP_LOW_CYC - 1) : CNT_W'(SLEEP_NORMAL_CYC - 1);
      ST_NVM_TEST: limit = lp ? CNT_W'(NVM_LOW_CYC - 1) : CNT_W'(NVM_NORMAL_CYC - 1);
      default:     limit = '0;
    endcase
    // ----------------------------------------
    // mode sequencing
    // ----------------------------------------
    case (r.state)
      ST_POWER_UP, ST_RECOVER, ST_WAKE, ST_NVM_TEST: begin
        if (r.cnt >= limit) begin
          next_r.state    = ST_RUN;
          next_r.cnt      = '0;
          next_r.base_cnt = '0;
          next_r.period_cnt = '0;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          next_r.state      = ST_SLEEP;
          next_r.data_valid = 1'b0;
          next_r.wake_cnt   = '0;
        end else if (nvm_test_req) begin
          next_r.state = ST_NVM_TEST;
          next_r.cnt   = '0;
        end else if (sync_mode) begin
          if (r.sync_s && !r.sync_d) begin
            next_r.sync_wait = 1'b1;
            next_r.sync_cnt  = '0;
          end else if (r.sync_wait) begin
            if (r.sync_cnt >= CNT_W'(SYNC_DRDY_CYC - 1)) begin
              next_r.sync_wait = 1'b0;
              sample_now       = 1'b1;
            end else begin
              next_r.sync_cnt = r.sync_cnt + 1'b1;
            end
          end
        end else begin
          next_r.sync_wait = 1'b0;
          if (r.base_cnt >= CNT_W'(BASE_CYC - 1)) begin
            next_r.base_cnt = '0;
            if (r.period_cnt >= period - 8'h01) begin
              next_r.period_cnt = '0;
              sample_now        = 1'b1;
            end else begin
              next_r.period_cnt = r.period_cnt + 8'h01;
            end
          end else begin
            next_r.base_cnt = r.base_cnt + 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (!r.cs_s) begin
          if (r.wake_cnt >= 10'(WAKE_PULSE_CYC - 1)) begin
            next_r.state = ST_WAKE;
            next_r.cnt   = '0;
          end else begin
            next_r.wake_cnt = r.wake_cnt + 10'h001;
          end
        end else begin
          next_r.wake_cnt = '0;
        end
      end
      default: next_r.state = ST_POWER_UP;
    endcase
    if (reset_req) begin
      next_r.state      = ST_RECOVER;
      next_r.cnt        = '0;
      next_r.data_valid = 1'b0;
      next_r.sync_wait  = 1'b0;
    end
    // ----------------------------------------
    // sample latch and data ready pulse
    // ----------------------------------------
    if (r.drdy_cnt != 8'h00) begin
      next_r.drdy_cnt = r.drdy_cnt - 8'h01;
    end else begin
      next_r.drdy = 1'b0;
    end
    if (sample_now && !reset_req) begin
      next_r.out_word   = sample_data;
      next_r.drdy       = 1'b1;
      next_r.drdy_cnt   = 8'(DRDY_PULSE_CYC - 1);
      next_r.data_valid = 1'b1;
    end
    // ----------------------------------------
    // serial slave, mode 3
    // ----------------------------------------
    if (r.state == ST_SLEEP || r.cs_s) begin
      next_r.bit_cnt = '0;
      if (r.cs_s && !r.cs_d) begin
        next_r.dout = 1'b0;
      end
    end else begin
      if (r.cs_d) begin
        next_r.tx_sh = r.out_word;
      end else if (!r.sclk_s && r.sclk_d) begin
        next_r.dout  = r.tx_sh[WORD_BITS-1];
        next_r.tx_sh = {r.tx_sh[WORD_BITS-2:0], 1'b0};
      end
      if (r.sclk_s && !r.sclk_d) begin
        next_r.rx_sh = {r.rx_sh[WORD_BITS-2:0], r.din_s};
        if (r.bit_cnt == 5'(WORD_BITS - 1)) begin
          next_r.bit_cnt  = '0;
          next_r.rx_word  = {r.rx_sh[WORD_BITS-2:0], r.din_s};
          next_r.rx_valid = 1'b1;
        end else begin
          next_r.bit_cnt = r.bit_cnt + 5'h01;
        end
      end
    end
    // status flags registered from the final next state
    next_r.nvm_busy = (next_r.state == ST_NVM_TEST);
    next_r.asleep   = (next_r.state == ST_SLEEP);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r        <= '0;
      r.state  <= ST_POWER_UP;
      r.sclk_m <= 1'b1;
      r.sclk_s <= 1'b1;
      r.sclk_d <= 1'b1;
      r.cs_m   <= 1'b1;
      r.cs_s   <= 1'b1;
      r.cs_d   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.dout           = r.dout;
  assign link.data_ready_pin = r.drdy;
  assign low_power           = r.low_power;
  assign data_valid          = r.data_valid;
  assign nvm_busy            = r.nvm_busy;
  assign asleep              = r.asleep;
  assign rx_word             = r.rx_word;
  assign rx_valid            = r.rx_valid;
endmodule : imu_sensor_end
`default_nettype wire

/* design/imu_host_end.sv */
// host end: serial master, wake pulse, word stall and sync clock source
`default_nettype none
module imu_host_end
  import imu_timing_pkg::*;
#(
  parameter int SYNC_CYC = SYNC_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // link
  imu_link_if.host                  link,
  // user side
  input  wire logic                 low_power,
  input  wire logic                 wake_req,
  input  wire logic                 sync_enable,
  input  wire logic [WORD_BITS-1:0] tx_word,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  output logic [WORD_BITS-1:0]      rx_word,
  output logic                      rx_valid,
  output logic                      data_ready
);
  import imu_timing_pkg::*;

  typedef struct packed {
    host_state_type       state;
    logic [10:0]          cnt;
    logic [4:0]           bit_cnt;
    logic [WORD_BITS-1:0] tx_sh;
    logic [WORD_BITS-1:0] rx_sh;
    logic                 sclk;
    logic                 cs_n;
    logic                 din;
    logic                 sync_out;
    logic [15:0]          sync_cnt;
    logic                 dout_m, dout_s;
    logic                 drdy_m, drdy_s, drdy_d;
    logic                 data_ready;
    logic [WORD_BITS-1:0] rx_word;
    logic                 rx_valid;
    logic                 tx_ready;
  } host_regs_type;

  host_regs_type r;
  host_regs_type next_r;
  logic [10:0]   half;
  logic [10:0]   stall;

  always_comb begin
    next_r          = r;
    next_r.rx_valid = 1'b0;
    half  = low_power ? 11'(SCLK_LOW_HALF - 1) : 11'(SCLK_NORMAL_HALF - 1);
    stall = low_power ? 11'(STALL_LOW_CYC - 1) : 11'(STALL_NORMAL_CYC - 1);
    next_r.dout_m     = link.dout;
    next_r.dout_s     = r.dout_m;
    next_r.drdy_m     = link.data_ready_pin;
    next_r.drdy_s     = r.drdy_m;
    next_r.drdy_d     = r.drdy_s;
    next_r.data_ready = r.drdy_s && !r.drdy_d;
    // ----------------------------------------
    // sync clock source
    // ----------------------------------------
    if (sync_enable) begin
      next_r.sync_cnt = (r.sync_cnt >= 16'(SYNC_CYC - 1)) ? 16'h0000 : r.sync_cnt + 16'h0001;
      next_r.sync_out = (r.sync_cnt < 16'(SYNC_HIGH_CYC));
    end else begin
      next_r.sync_cnt = '0;
      next_r.sync_out = 1'b0;
    end
    // ----------------------------------------
    // serial master, mode 3
    // ----------------------------------------
    case (r.state)
      H_IDLE: begin
        next_r.sclk = 1'b1;
        next_r.cnt  = '0;
        if (wake_req) begin
          next_r.cs_n     = 1'b0;
          next_r.tx_ready = 1'b0;
          next_r.state    = H_WAKE;
        end else if (tx_valid) begin
          next_r.cs_n     = 1'b0;
          next_r.tx_sh    = tx_word;
          next_r.bit_cnt  = '0;
          next_r.tx_ready = 1'b0;
          next_r.state    = H_SHIFT;
        end
      end
      H_WAKE: begin
        if (r.cnt >= 11'(WAKE_PULSE_CYC - 1)) begin
          next_r.cs_n  = 1'b1;
          next_r.cnt   = '0;
          next_r.state = H_STALL;
        end else begin
          next_r.cnt = r.cnt + 11'h001;
        end
      end
      H_SHIFT: begin
        if (r.cnt >= half) begin
          next_r.cnt = '0;
          if (r.bit_cnt == 5'(WORD_BITS)) begin
            next_r.cs_n     = 1'b1;
            next_r.rx_word  = r.rx_sh;
            next_r.rx_valid = 1'b1;
            next_r.state    = H_STALL;
          end else if (r.sclk) begin
            next_r.sclk  = 1'b0;
            next_r.din   = r.tx_sh[WORD_BITS-1];
            next_r.tx_sh = {r.tx_sh[WORD_BITS-2:0], 1'b0};
          end else begin
            next_r.sclk    = 1'b1;
            next_r.rx_sh   = {r.rx_sh[WORD_BITS-2:0], r.dout_s};
            next_r.bit_cnt = r.bit_cnt + 5'h01;
          end
        end else begin
          next_r.cnt = r.cnt + 11'h001;
        end
      end
      H_STALL: begin
        if (r.cnt >= stall) begin
          next_r.state    = H_IDLE;
          next_r.tx_ready = 1'b1;
          next_r.cnt      = '0;
        end else begin
          next_r.cnt = r.cnt + 11'h001;
        end
      end
      default: next_r.state = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r          <= '0;
      r.state    <= H_IDLE;
      r.sclk     <= 1'b1;
      r.cs_n     <= 1'b1;
      r.tx_ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.sclk             = r.sclk;
  assign link.cs_n             = r.cs_n;
  assign link.din              = r.din;
  assign link.sync_clock_input = r.sync_out;
  assign tx_ready              = r.tx_ready;
  assign rx_word               = r.rx_word;
  assign rx_valid              = r.rx_valid;
  assign data_ready            = r.data_ready;
endmodule : imu_host_end
`default_nettype wire

/* verification/imu_link_checker.sv */
// assertions on the wires between the host and sensor ends
`default_nettype none
module imu_link_checker #(
  parameter int SYNC_DRDY_CYC = 150
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic data_ready_pin,
  input wire logic sync_clock_input
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DRDY_HI = SYNC_DRDY_CYC + 8;
  logic        prev_sclk;
  logic [15:0] run;
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;
  logic [4:0]  rises;
  // ----------------------------------------
  // run lengths of the serial wires
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_sclk <= 1'b1;
      run       <= '1;
      low_cnt   <= '0;
      high_cnt  <= '1;
      rises     <= '0;
    end else begin
      prev_sclk <= sclk;
      run       <= (sclk != prev_sclk) ? 16'h0001 : run + {15'h0000, ~&run};
      low_cnt   <= cs_n ? 16'h0000 : low_cnt + {15'h0000, ~&low_cnt};
      high_cnt  <= cs_n ? high_cnt + {15'h0000, ~&high_cnt} : 16'h0000;
      rises     <= cs_n ? 5'h00 : rises + {4'h0, sclk & ~prev_sclk};
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_idle_high;
    cs_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial clock low while deselected");
  property p_din_stable;
    (!cs_n && sclk && !prev_sclk) |-> $stable(din);
  endproperty
  a_din_stable: assert property (p_din_stable) else $error("din moved at rising clock");
  property p_half;
    (!cs_n && (sclk != prev_sclk)) |-> run >= 16'd7;
  endproperty
  a_half: assert property (p_half) else $error("serial clock phase too short");
  property p_stall;
    $fell(cs_n) |-> high_cnt >= 16'd225;
  endproperty
  a_stall: assert property (p_stall) else $error("stall between words too short");
  property p_wake;
    ($rose(cs_n) && rises == 5'd0) |-> low_cnt >= 16'd500;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse too short");
  property p_frame;
    $rose(cs_n) |-> (rises == 5'd16 || rises == 5'd0);
  endproperty
  a_frame: assert property (p_frame) else $error("frame not sixteen clocks");
  property p_dout_idle;
    $rose(cs_n) |-> ##6 !dout;
  endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("dout not released");
  property p_drdy_pulse;
    $rose(data_ready_pin) |-> (data_ready_pin throughout (##99 1'b1)) ##1 !data_ready_pin;
  endproperty
  a_drdy_pulse: assert property (p_drdy_pulse) else $error("data ready pulse length wrong");
  property p_sync_drdy;
    $rose(sync_clock_input) |-> ##[SYNC_DRDY_CYC:DRDY_HI] $rose(data_ready_pin);
  endproperty
  a_sync_drdy: assert property (p_sync_drdy) else $error("data ready late after sync");
  property p_sync_high;
    $rose(sync_clock_input) |-> sync_clock_input throughout (##124 1'b1);
  endproperty
  a_sync_high: assert property (p_sync_high) else $error("sync high pulse too short");
endmodule : imu_link_checker
`default_nettype wire

/* verification/inertial_sensor_mode_timing_bench.sv */
// testbench joining the host and sensor ends over the link
`default_nettype none
module inertial_sensor_mode_timing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import imu_timing_pkg::*;
  localparam int STN = 400, STL = 600, RSN = 300, RSL = 500, SLN = 200, SLL = 360;
  localparam int NVN = 250, NVL = 450, BASE = 300, SDR = 150;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  setting = 8'h05;
  logic [15:0] sample = 16'ha5c3;
  logic        sync_mode = 1'b0, reset_req = 1'b0, sleep_req = 1'b0, nvm_req = 1'b0;
  logic        wake_req = 1'b0, sync_en = 1'b0, tx_valid = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic        low_power, data_valid, nvm_busy, asleep, s_rx_valid, tx_ready, h_rx_valid, data_ready;
  logic [15:0] s_rx_word, h_rx_word, s_got;
  int          failures = 0;
  int          samples_checked = 0;
  int          n;
  imu_link_if  link ();
  always #20 ref_clk = ~ref_clk;
  // ----------------------------------------
  // the two ends and the checker
  // ----------------------------------------
  imu_sensor_end #(.STARTUP_NORMAL_CYC(STN), .STARTUP_LOW_CYC(STL), .RESET_NORMAL_CYC(RSN),
    .RESET_LOW_CYC(RSL), .SLEEP_NORMAL_CYC(SLN), .SLEEP_LOW_CYC(SLL), .NVM_NORMAL_CYC(NVN),
    .NVM_LOW_CYC(NVL), .BASE_CYC(BASE), .SYNC_DRDY_CYC(SDR)) i_imu_sensor_end (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .sample_period_setting(setting),
    .sample_data(sample), .sync_mode(sync_mode), .reset_req(reset_req), .sleep_req(sleep_req),
    .nvm_test_req(nvm_req), .low_power(low_power), .data_valid(data_valid), .nvm_busy(nvm_busy),
    .asleep(asleep), .rx_word(s_rx_word), .rx_valid(s_rx_valid));
  imu_host_end #(.SYNC_CYC(2700)) i_imu_host_end (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .low_power(low_power), .wake_req(wake_req),
    .sync_enable(sync_en), .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_word(h_rx_word), .rx_valid(h_rx_valid), .data_ready(data_ready));
  imu_link_checker #(.SYNC_DRDY_CYC(SDR)) i_imu_link_checker (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din),
    .dout(link.dout), .data_ready_pin(link.data_ready_pin), .sync_clock_input(link.sync_clock_input));
  always @(posedge ref_clk) if (s_rx_valid === 1'b1) s_got <= s_rx_word;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_span(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("wrong value at %0t: span %0d, expected %0d to %0d", $time, got, lo, hi);
    end
  endtask : check_span
  function automatic logic hit(input int sel);
    case (sel)
      0: hit = data_valid === 1'b1;
      1: hit = nvm_busy === 1'b0;
      2: hit = asleep === 1'b1;
      3: hit = asleep === 1'b0;
      4: hit = tx_ready === 1'b1;
      5: hit = h_rx_valid === 1'b1;
      6: hit = data_ready === 1'b1;
      7: hit = nvm_busy === 1'b1;
      8: hit = data_valid === 1'b0;
      9: hit = link.sync_clock_input === 1'b1;
      default: hit = link.sync_clock_input === 1'b0;
    endcase
  endfunction : hit
  // counts settled clock edges until the condition holds
  task automatic wait_for(input int sel, input int limit, output int cnt);
    cnt = 0;
    while (!hit(sel) && cnt < limit) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
    if (cnt >= limit) begin
      failures++;
      $display("wrong value at %0t: wait %0d timed out", $time, sel);
    end
  endtask : wait_for
  task automatic pulse(input int sel);
    @(posedge ref_clk);
    case (sel)
      0: reset_req <= 1'b1;
      1: sleep_req <= 1'b1;
      2: nvm_req <= 1'b1;
      default: wake_req <= 1'b1;
    endcase
    @(posedge ref_clk);
    {reset_req, sleep_req, nvm_req, wake_req} <= 4'h0;
    #1;
  endtask : pulse
  task automatic xfer(input logic [15:0] w);
    wait_for(4, 4000, n);
    @(posedge ref_clk);
    tx_word  <= w;
    tx_valid <= 1'b1;
    @(posedge ref_clk);
    tx_valid <= 1'b0;
    #1;
    wait_for(5, 3000, n);
    @(posedge ref_clk);
    #1;
    check_word(h_rx_word, sample);
    check_word(s_got, w);
  endtask : xfer
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int per, rst, nvm, slp;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    wait_for(0, 3000, n);
    check_span(n, STN, STN + 5 * BASE + 10);
    check_word({15'h0000, low_power}, 16'h0000);
    $display("test start-up done");
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      setting <= m[0] ? 8'h0a : 8'h09;
      sample  <= m[0] ? 16'h3c5a : 16'h5aa5;
      per = m[0] ? 10 * BASE : 9 * BASE;
      rst = m[0] ? RSL : RSN;
      nvm = m[0] ? NVL : NVN;
      slp = m[0] ? SLL : SLN;
      for (int k = 0; k < 3; k++) begin
        @(posedge ref_clk);
        #1;
        wait_for(6, 4000, n);
      end
      check_span(n + 1, per - 1, per + 1);
      check_word({15'h0000, low_power}, {15'h0000, m[0]});
      xfer(16'h1234 + 16'(m));
      xfer(16'hbeef - 16'(m));
      pulse(0);
      wait_for(8, 20, n);
      wait_for(0, 6000, n);
      check_span(n, rst + per - 3, rst + per + 3);
      pulse(2);
      wait_for(7, 20, n);
      wait_for(1, 2000, n);
      check_span(n, nvm - 2, nvm + 2);
      pulse(1);
      wait_for(2, 20, n);
      pulse(3);
      wait_for(3, 2000, n);
      check_span(n, 500, 520);
      wait_for(0, 5000, n);
      check_span(n, slp + per - 3, slp + per + 3);
      $display("test mode %0d done", m);
    end
    @(posedge ref_clk);
    sync_mode <= 1'b1;
    repeat (20) @(posedge ref_clk);
    sync_en <= 1'b1;
    repeat (3) begin
      wait_for(10, 500, n);
      wait_for(9, 3000, n);
      wait_for(6, 300, n);
      check_span(n, SDR, SDR + 12);
    end
    $display("test sync done");
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    $display("wrong value at %0t: run timed out", $time);
    stop_test();
  end
endmodule : inertial_sensor_mode_timing_bench
`default_nettype wire
